// ==== inc/scw_regs.vh ====
`ifndef SCW_REGS_VH
`define SCW_REGS_VH

// register byte offsets
`define SCW_ADDR_TIMING 12'h000
`define SCW_ADDR_STATUS 12'h004
`define SCW_ADDR_WIDTH 12

// timing register fields
`define SCW_CLOSE_WAIT_HI 14
`define SCW_CLOSE_WAIT_LO 13
`define SCW_RSVD_BIT 12
`define SCW_ACT_WAIT_HI 11
`define SCW_ACT_WAIT_LO 10
`define SCW_CLOSE_WAIT_RST 2'h0
`define SCW_ACT_WAIT_RST 2'h1

// status register fields
`define SCW_STAT_CLOSE_BUSY 0
`define SCW_STAT_ACT_BUSY 1

// command codes on the request port
`define SCW_CMD_W 3
`define SCW_CMD_NOP 3'h0
`define SCW_CMD_ACTIVATE 3'h1
`define SCW_CMD_FETCH 3'h2
`define SCW_CMD_STORE 3'h3
`define SCW_CMD_CLOSE_ONE 3'h4
`define SCW_CMD_CLOSE_ALL 3'h5
`define SCW_CMD_RENEW 3'h6
`define SCW_CMD_RETAIN 3'h7

`define SCW_BANKS 4
`define SCW_BANK_W 2
`define SCW_CNT_W 2
`define SCW_CNT_ZERO 2'h0

`endif

// ==== core/scw_wait_counter.v ====
`timescale 1ns/1ps
`include "scw_regs.vh"

// down-counter: loads on trigger, busy until zero
module scw_wait_counter (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire load_in,
    input wire [`SCW_CNT_W-1:0] value_in,
    output wire busy_out
);
    reg [`SCW_CNT_W-1:0] count;

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= `SCW_CNT_ZERO;
        end else if (load_in) begin
            count <= value_in; // R9
        end else if (count != `SCW_CNT_ZERO) begin
            count <= count - 2'h1;
        end
    end

    assign busy_out = (count != `SCW_CNT_ZERO); // R9
endmodule

// ==== core/scw_apb_regs.v ====
`timescale 1ns/1ps
`include "scw_regs.vh"

// apb slave with timing and status registers, zero wait states
module scw_apb_regs (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SCW_ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [1:0] status_in,
    output reg [`SCW_CNT_W-1:0] close_wait_out,
    output reg [`SCW_CNT_W-1:0] act_wait_out
);
    wire access = psel && penable;
    wire hit_timing = (paddr == `SCW_ADDR_TIMING);
    wire hit_status = (paddr == `SCW_ADDR_STATUS);

    assign pready = 1'b1;
    assign pslverr = access && !hit_timing && !hit_status;

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            close_wait_out <= `SCW_CLOSE_WAIT_RST;
            act_wait_out <= `SCW_ACT_WAIT_RST;
        end else if (access && pwrite && hit_timing) begin
            close_wait_out <= pwdata[`SCW_CLOSE_WAIT_HI:`SCW_CLOSE_WAIT_LO]; // R1
            act_wait_out <= pwdata[`SCW_ACT_WAIT_HI:`SCW_ACT_WAIT_LO]; // R8
        end
    end

    always @* begin
        prdata = 32'h0000_0000;
        if (hit_timing) begin
            prdata[`SCW_CLOSE_WAIT_HI:`SCW_CLOSE_WAIT_LO] = close_wait_out;
            prdata[`SCW_ACT_WAIT_HI:`SCW_ACT_WAIT_LO] = act_wait_out;
            prdata[`SCW_RSVD_BIT] = 1'b0; // R7
        end else if (hit_status) begin
            prdata[`SCW_STAT_ACT_BUSY:`SCW_STAT_CLOSE_BUSY] = status_in;
        end
    end
endmodule

// ==== core/scw_command_spacer.v ====
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "scw_regs.vh"

// Behaviour
// R1 - bits 14:13 set bank-close wait
// R2 - auto close to activate same bank waits
// R3 - close commands to activate same bank wait
// R4 - close-all to renew waits
// R5 - close-all to retain waits
// R6 - close wait code is binary count
// R7 - bit 12 reads zero, write zero
// R8 - bits 11:10 set activate-to-column wait
// R9 - down-counters gate dependent commands
module scw_command_spacer (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SCW_ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire req_valid_in,
    input wire [`SCW_CMD_W-1:0] req_cmd_in,
    input wire [`SCW_BANK_W-1:0] req_bank_in,
    input wire req_auto_close_in,
    output wire req_ready_out,
    output reg cmd_valid_out,
    output reg [`SCW_CMD_W-1:0] cmd_out,
    output reg [`SCW_BANK_W-1:0] cmd_bank_out,
    output reg cmd_auto_close_out
);
    wire [`SCW_CNT_W-1:0] close_wait;
    wire [`SCW_CNT_W-1:0] act_wait;
    wire [`SCW_BANKS-1:0] bank_busy;
    wire [`SCW_BANKS-1:0] bank_load;
    wire all_busy;
    wire act_busy;
    wire any_bank_busy = |bank_busy;

    scw_apb_regs u_regs (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status_in({act_busy, any_bank_busy || all_busy}),
        .close_wait_out(close_wait),
        .act_wait_out(act_wait)
    );

    wire is_act = (req_cmd_in == `SCW_CMD_ACTIVATE);
    wire is_col = (req_cmd_in == `SCW_CMD_FETCH) || (req_cmd_in == `SCW_CMD_STORE);
    wire is_close_one = (req_cmd_in == `SCW_CMD_CLOSE_ONE);
    wire is_close_all = (req_cmd_in == `SCW_CMD_CLOSE_ALL);
    wire is_renew = (req_cmd_in == `SCW_CMD_RENEW);
    wire is_retain = (req_cmd_in == `SCW_CMD_RETAIN);

    // blocking conditions per command
    wire act_blocked = is_act && bank_busy[req_bank_in]; // R2 R3
    wire col_blocked = is_col && act_busy; // R8
    wire all_blocked = (is_renew && all_busy) || (is_retain && all_busy); // R4 R5
    assign req_ready_out = !(act_blocked || col_blocked || all_blocked);
    wire issue = req_valid_in && req_ready_out;

    // a counter loaded with n holds off n following cycles
    wire col_trigger = issue && is_col && req_auto_close_in;
    wire all_trigger = issue && is_close_all;

    genvar b;
    generate
        for (b = 0; b < `SCW_BANKS; b = b + 1) begin : g_bank
            assign bank_load[b] = all_trigger ||
                (issue && is_close_one && (req_bank_in == b)) ||
                (col_trigger && (req_bank_in == b)); // R2 R3
            scw_wait_counter u_bank (
                .sys_clk_in(sys_clk_in),
                .rst_n_in(rst_n_in),
                .load_in(bank_load[b]),
                .value_in(close_wait), // R6
                .busy_out(bank_busy[b])
            );
        end
    endgenerate

    scw_wait_counter u_all (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(all_trigger), // R4 R5
        .value_in(close_wait),
        .busy_out(all_busy)
    );

    scw_wait_counter u_act (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(issue && is_act), // R8
        .value_in(act_wait),
        .busy_out(act_busy)
    );

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_valid_out <= 1'b0;
            cmd_out <= `SCW_CMD_NOP;
            cmd_bank_out <= {`SCW_BANK_W{1'b0}};
            cmd_auto_close_out <= 1'b0;
        end else begin
            cmd_valid_out <= issue;
            cmd_out <= issue ? req_cmd_in : `SCW_CMD_NOP;
            cmd_bank_out <= issue ? req_bank_in : {`SCW_BANK_W{1'b0}};
            cmd_auto_close_out <= issue && is_col && req_auto_close_in;
        end
    end
endmodule

// ==== test/scw_chk.sv ====
`timescale 1ns/1ps
module scw_chk (
    input wire sys_clk_in, input wire rst_n_in,
    input wire psel, input wire penable, input wire pwrite,
    input wire [11:0] paddr, input wire [31:0] pwdata, input wire [31:0] prdata,
    input wire pslverr, input wire req_valid_in, input wire [2:0] req_cmd_in,
    input wire req_ready_out, input wire cmd_valid_out, input wire [2:0] cmd_out,
    input wire [1:0] req_bank_in,
    input wire req_auto_close_in,
    input wire [1:0] cmd_bank_out,
    input wire cmd_auto_close_out
);
    logic [1:0] cw, aw;
    logic [2:0] cc, ac;
    // cycles since the last close-all and the last activate left the block
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cw <= 2'h0; aw <= 2'h1; cc <= 3'h7; ac <= 3'h7;
        end else begin
            if (psel && penable && pwrite && paddr == 12'h000) begin
                cw <= pwdata[14:13]; aw <= pwdata[11:10];
            end
            cc <= (cmd_valid_out && cmd_out == 3'h5) ? 3'h1 : ((cc == 3'h7) ? cc : cc + 3'h1);
            ac <= (cmd_valid_out && cmd_out == 3'h1) ? 3'h1 : ((ac == 3'h7) ? ac : ac + 3'h1);
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_issue_follows: assert property (req_valid_in && req_ready_out |=>
        cmd_valid_out && cmd_out == $past(req_cmd_in)) else $error("command not issued");
    a_bank_follows: assert property (req_valid_in && req_ready_out |=>
        cmd_bank_out == $past(req_bank_in)) else $error("command bank not carried");
    a_auto_close_flag: assert property (req_valid_in && req_ready_out |=>
        cmd_auto_close_out ==
        $past(req_auto_close_in && (req_cmd_in == 3'h2 || req_cmd_in == 3'h3)))
        else $error("auto close flag wrong");
    a_close_act_gap: assert property (cmd_valid_out && cmd_out == 3'h1 |-> cc > cw)
        else $error("activate too soon after close");
    a_close_renew_gap: assert property (cmd_valid_out && cmd_out == 3'h6 |-> cc > cw)
        else $error("renew too soon after close");
    a_close_retain_gap: assert property (cmd_valid_out && cmd_out == 3'h7 |-> cc > cw)
        else $error("retain too soon after close");
    a_act_col_gap: assert property (cmd_valid_out && cmd_out inside {3'h2, 3'h3} |-> ac > aw)
        else $error("column too soon after activate");
    a_act_stall: assert property (req_valid_in && req_cmd_in == 3'h1 && cc < cw |-> !req_ready_out)
        else $error("activate not held off");
    a_rsvd_zero: assert property (psel && !pwrite |-> prdata[12] == 1'b0)
        else $error("reserved bit reads one");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h004 |-> pslverr)
        else $error("unmapped access not refused");
endmodule
bind scw_command_spacer scw_chk scw_chk_inst (.*);

// ==== test/scw_sdram_model.sv ====
`timescale 1ns/1ps
// counts commands reaching the memory pins
module scw_sdram_model (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire cmd_valid_in,
    output logic [15:0] count_out
);
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) count_out <= 16'h0000;
        else if (cmd_valid_in) count_out <= count_out + 16'h0001;
    end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic sys_clk_in = 0, rst_n_in = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic req_valid_in = 0, req_auto_close_in = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [2:0] req_cmd_in = 0;
    logic [1:0] req_bank_in = 0, n, m, bk;
    wire [31:0] prdata;
    wire pready, pslverr, req_ready_out, cmd_valid_out, cmd_auto_close_out;
    wire [2:0] cmd_out;
    wire [1:0] cmd_bank_out;
    wire [15:0] seen;
    int mismatches = 0, tests_run = 0, issued = 0, w;
    scw_command_spacer scw_command_spacer_inst (.*);
    scw_sdram_model scw_sdram_model_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .cmd_valid_in(cmd_valid_out), .count_out(seen));
    initial forever #5 sys_clk_in = ~sys_clk_in;
    task chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("compared %0d, mismatched %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task apb(input wr, input [11:0] a, input [31:0] d);
        @(posedge sys_clk_in); psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge sys_clk_in); penable <= 1;
        @(posedge sys_clk_in); while (pready !== 1'b1) @(posedge sys_clk_in);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask
    // held until accepted or 20 stalled cycles; w counts stalled cycles
    task cmd(input [2:0] c, input ac, input [1:0] b);
        req_valid_in <= 1;
        req_cmd_in <= c;
        req_bank_in <= b;
        req_auto_close_in <= ac;
        w = 0;
        @(negedge sys_clk_in);
        while (req_ready_out !== 1'b1 && w < 20) begin
            @(negedge sys_clk_in); w++;
        end
        @(posedge sys_clk_in); issued++;
    endtask
    // trigger on bank bk, dependent command on bank b2
    task pair(input [2:0] t, input a, input [2:0] d, input [1:0] x, input [1:0] b2);
        cmd(t, a, bk);
        cmd(d, 1'b0, b2);
        chk(w, x);
        req_valid_in <= 0; @(posedge sys_clk_in);
    endtask
    initial begin
        w = $urandom(32'hD0FD);
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1;
        apb(0, 12'h000, 0); chk(rd, 32'h0000_0400);
        apb(1, 12'h000, 32'h0000_6C00); apb(0, 12'h000, 0); chk(rd, 32'h0000_6C00);
        apb(0, 12'h010, 0); chk(er, 1);
        for (int i = 0; i < 12; i++) begin
            n = (i < 4) ? 2'(i) : 2'($urandom_range(3));
            m = n % 2'h3;
            bk = 2'($urandom_range(3));
            apb(1, 12'h000, {17'h0, n, 1'b0, m, 10'h0});
            pair(3'h5, 0, 3'h1, n, bk);
            pair(3'h4, 0, 3'h1, n, bk);
            pair(3'h5, 0, 3'h6, n, bk);
            pair(3'h5, 0, 3'h7, n, bk);
            pair(3'h3, 1, 3'h1, n, bk);
            pair(3'h1, 0, 3'h2, m, bk);
            pair(3'h4, 0, 3'h1, 2'h0, 2'(bk + 2'h1));
            $display("round %0d done", i);
        end
        // counters idle, and lets the last command reach the model
        apb(0, 12'h004, 0); chk(rd, 32'h0000_0000);
        chk(seen, issued);
        tally_and_finish;
    end
    initial begin
        #60000;
        mismatches++;
        tally_and_finish;
    end
endmodule
